// File: ddi_regs.svh
/*
  Constants for the serial-bus master that drives the dual DAC port.
  Assumes it is included by bare name from the controller, the slave model and the bench.
*/
`ifndef DDI_REGS_SVH
`define DDI_REGS_SVH
`define DDI_ADDR_FIXED 5'h03
`define DDI_SEL_VDD 2'h0
`define DDI_SEL_OPEN 2'h2
`define DDI_SEL_GND 2'h3
`define DDI_HS_CODE 8'h08
`define DDI_CMD_REF 3'h7
`define DDI_CH_A 3'h0
`define DDI_CH_B 3'h1
`define DDI_CH_ALL 3'h7
`define DDI_SYS_NS 50
`define DDI_STD_NS 10000
`define DDI_FAST_NS 2500
`define DDI_HS_NS 300
`define DDI_READ_BYTES 2'h3
`endif

// File: ddi_pkg.sv
/*
  Types for the dual DAC serial-bus master.
  Assumes ddi_regs.svh is on the include path.
*/
package ddi_pkg;
  typedef enum logic [1:0] {
    DDI_SPD_STD = 2'h0,
    DDI_SPD_FAST = 2'h1,
    DDI_SPD_HS = 2'h2
  } ddi_speed_t;
endpackage

// File: ddi_master.sv
/*
  Serial-bus master that writes 24-bit command words to, and reads three bytes
  from, the dual DAC slave port, with optional high-speed entry.
  Assumes open-drain bus wiring with pull-ups outside; SCL and SDA levels are
  seen back through the pin inputs.
*/
// How it works
// - Start is SDA falling with SCL high, then address; slave acks bit nine
// - Nine clocks per byte, MSB first; SDA changes only while SCL low
// - Write ends with SDA released high during tenth clock, forming stop
// - Read: master nacks last byte, then low then high on SDA for stop
// - Write sends address with direction 0, command, high, low, then stop
// - Read sends address with direction 1, takes three bytes, then stop
// - High-speed entry: master code unacked, repeated start, then address
// - Reserved top bit of the command byte always sent as zero
// - Command code three bits below multi-byte bit; channel in low three
// - Multi-byte set: further data pairs follow without a new command
// - Multi-byte clear: each block carries its own fresh command byte
`timescale 1ns/1ns
`include "ddi_regs.svh"
module ddi_master #(
  parameter int RES_BITS = 16,
  parameter bit HS_ENABLE = 1'b1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // User request
  input wire logic req,
  input wire logic rd,
  input wire logic more,
  input wire logic hs,
  input wire logic [1:0] speed,
  input wire logic [1:0] sel,
  input wire logic [2:0] cmd,
  input wire logic [2:0] chan,
  input wire logic [15:0] code,
  input wire logic clear_input,
  // User answer
  output logic busy,
  output logic want_data,
  output logic done,
  output logic nack,
  output logic [23:0] rdata,
  // Bus pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  // ---------------------------------------------------------------
  // Types and helpers
  // ---------------------------------------------------------------
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01, ST_START = 8'h02, ST_BIT = 8'h04, ST_ACK = 8'h08,
    ST_NEXT = 8'h10, ST_STOP = 8'h20, ST_RSTART = 8'h40, ST_WAIT = 8'h80
  } ddi_state_t;
  // Quarters round up, so a rate never exceeds its bus limit
  localparam int QTR_STD = (`DDI_STD_NS / 4 + `DDI_SYS_NS - 1) / `DDI_SYS_NS;
  localparam int QTR_FAST = (`DDI_FAST_NS / 4 + `DDI_SYS_NS - 1) / `DDI_SYS_NS;
  localparam int QTR_HS = (`DDI_HS_NS / 4 + `DDI_SYS_NS - 1) / `DDI_SYS_NS;

  // Quarter-period length for a rate; HS falls back when not built in
  function automatic logic [7:0] qtr(input logic [1:0] s, input logic h);
    if (h) begin
      qtr = 8'(QTR_HS);
    end else if (s == ddi_pkg::DDI_SPD_FAST) begin
      qtr = 8'(QTR_FAST);
    end else begin
      qtr = 8'(QTR_STD);
    end
  endfunction

  // Left-align the channel code; lower bits beyond the width go out as zero
  function automatic logic [15:0] align(input logic [15:0] c);
    align = c << (16 - RES_BITS);
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] sda_sync;
  logic [1:0] scl_sync;
  logic [1:0] clr_sync;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sda_sync <= 2'h3;
      scl_sync <= 2'h3;
      clr_sync <= 2'h3;
    end else begin
      sda_sync <= {sda_sync[0], sda_in};
      scl_sync <= {scl_sync[0], scl_in};
      clr_sync <= {clr_sync[0], clear_input};
    end
  end
  wire sda_s = sda_sync[1];
  wire scl_s = scl_sync[1];

  // ---------------------------------------------------------------
  // Controller state
  // ---------------------------------------------------------------
  ddi_state_t state, next_state;
  logic [7:0] tmr, next_tmr;
  logic [1:0] ph, next_ph;
  logic [2:0] bitn, next_bitn;
  logic [1:0] bcnt, next_bcnt;
  logic [7:0] sh, next_sh;
  logic [15:0] dat, next_dat;
  logic rdm, next_rdm;
  logic mb, next_mb;
  logic hsm, next_hsm;
  logic hsa, next_hsa;
  logic addr_ph, next_addr_ph;
  logic cmd_sent, next_cmd_sent;
  logic [23:0] rsh, next_rsh;
  logic next_busy, next_want, next_done, next_nack;
  logic [23:0] next_rdata;
  logic next_scl, next_sda;

  wire tick = (tmr == 8'h00);
  wire [7:0] rel = qtr(speed, hsm) - 8'h01;
  wire [7:0] abyte = {`DDI_ADDR_FIXED, sel, rdm};

  // Next-state logic: each bit is four quarter phases, SCL high in 2 and 3
  always_comb begin
    next_state = state;
    next_tmr = tick ? rel : tmr - 8'h01;
    next_ph = ph;
    next_bitn = bitn;
    next_bcnt = bcnt;
    next_sh = sh;
    next_dat = dat;
    next_rdm = rdm;
    next_mb = mb;
    next_hsm = hsm;
    next_hsa = hsa;
    next_addr_ph = addr_ph;
    next_cmd_sent = cmd_sent;
    next_rsh = rsh;
    next_busy = busy;
    next_want = 1'b0;
    next_done = 1'b0;
    next_nack = nack;
    next_rdata = rdata;
    next_scl = scl_out;
    next_sda = sda_out;
    if (hsm && !clr_sync[1]) begin
      next_hsm = 1'b0;
    end
    unique case (state)
      ST_IDLE: begin
        next_scl = 1'b1;
        next_sda = 1'b1;
        if (req) begin
          next_busy = 1'b1;
          next_nack = 1'b0;
          next_rdm = rd;
          next_mb = more;
          next_hsa = hs && HS_ENABLE;
          next_dat = align(code);
          next_cmd_sent = 1'b0;
          next_ph = 2'h0;
          next_tmr = rel;
          next_state = ST_START;
        end
      end
      ST_START, ST_RSTART: if (tick) begin
        // SDA falls while SCL high, then SCL falls
        next_ph = ph + 2'h1;
        if (ph == 2'h0) begin
          next_scl = 1'b1;
          next_sda = 1'b1;
        end else if (ph == 2'h1 && scl_s) begin
          next_sda = 1'b0;
        end else if (ph == 2'h2) begin
          next_scl = 1'b0;
        end else if (ph == 2'h3) begin
          next_sh = hsa ? `DDI_HS_CODE : abyte;
          next_addr_ph = 1'b1;
          next_bitn = 3'h7;
          next_ph = 2'h0;
          next_state = ST_BIT;
        end else begin
          next_ph = ph;
        end
      end
      ST_BIT, ST_ACK: if (tick) begin
        next_ph = ph + 2'h1;
        unique case (ph)
          2'h0: begin
            // Drive data only while SCL low
            if (state == ST_BIT) begin
              next_sda = (rdm && !addr_ph) ? 1'b1 : sh[7];
            end else begin
              next_sda = !(rdm && !addr_ph && bcnt != `DDI_READ_BYTES - 2'h1) ? 1'b1 : 1'b0;
            end
          end
          2'h1: next_scl = 1'b1;
          2'h2: begin
            // Wait out clock stretching before sampling
            if (!scl_s) begin
              next_ph = ph;
            end else if (state == ST_BIT) begin
              next_sh = {sh[6:0], sda_s};
            end else if (addr_ph || !rdm) begin
              if (sda_s && !hsa) begin
                next_nack = 1'b1;
              end
            end
          end
          default: begin
            next_scl = 1'b0;
            next_ph = 2'h0;
            if (state == ST_BIT) begin
              next_bitn = bitn - 3'h1;
              if (bitn == 3'h0) begin
                next_state = ST_ACK;
              end
            end else begin
              next_state = ST_NEXT;
            end
          end
        endcase
      end
      ST_NEXT: begin
        // Choose what follows each acknowledged byte
        next_addr_ph = 1'b0;
        next_bitn = 3'h7;
        if (hsa) begin
          next_hsa = 1'b0;
          next_hsm = 1'b1;
          next_state = ST_RSTART;
        end else if (nack) begin
          next_state = ST_STOP;
        end else if (addr_ph) begin
          next_bcnt = 2'h0;
          next_rsh = 24'h000000;
          next_sh = {1'b0, mb, cmd, chan};
          next_state = rdm ? ST_BIT : ST_BIT;
        end else if (rdm) begin
          next_rsh = {rsh[15:0], sh};
          next_bcnt = bcnt + 2'h1;
          if (bcnt == `DDI_READ_BYTES - 2'h1) begin
            next_rdata = {rsh[15:0], sh};
            next_state = ST_STOP;
          end else begin
            next_state = ST_BIT;
          end
        end else begin
          next_bcnt = bcnt + 2'h1;
          unique case (bcnt)
            2'h0: begin
              next_sh = dat[15:8];
              next_cmd_sent = 1'b1;
              next_state = ST_BIT;
            end
            2'h1: begin
              next_sh = dat[7:0];
              next_state = ST_BIT;
            end
            default: begin
              // Block whole; ask for another or stop
              next_want = 1'b1;
              next_state = ST_WAIT;
            end
          endcase
        end
      end
      ST_WAIT: begin
        if (req && !rd) begin
          next_dat = align(code);
          if (mb) begin
            next_sh = next_dat[15:8];
            next_bcnt = 2'h1;
          end else begin
            next_sh = {1'b0, more, cmd, chan};
            next_mb = more;
            next_bcnt = 2'h0;
          end
          next_tmr = rel;
          next_state = ST_BIT;
        end else if (!req) begin
          next_state = ST_STOP;
        end
      end
      ST_STOP: if (tick) begin
        // SDA low under low SCL, raise SCL, then release SDA
        next_ph = ph + 2'h1;
        unique case (ph)
          2'h0: next_sda = 1'b0;
          2'h1: next_scl = 1'b1;
          2'h2: begin
            // Hold SDA low until SCL is seen high, else the stop is lost
            if (scl_s) begin
              next_sda = 1'b1;
            end else begin
              next_ph = ph;
            end
          end
          default: begin
            next_ph = 2'h0;
            next_hsm = 1'b0;
            next_busy = 1'b0;
            next_done = 1'b1;
            next_state = ST_IDLE;
          end
        endcase
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Register all state; outputs except the two pin enables come straight from these flops
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      tmr <= 8'h00;
      ph <= 2'h0;
      bitn <= 3'h7;
      bcnt <= 2'h0;
      sh <= 8'h00;
      dat <= 16'h0000;
      rdm <= 1'b0;
      mb <= 1'b0;
      hsm <= 1'b0;
      hsa <= 1'b0;
      addr_ph <= 1'b0;
      cmd_sent <= 1'b0;
      rsh <= 24'h000000;
      busy <= 1'b0;
      want_data <= 1'b0;
      done <= 1'b0;
      nack <= 1'b0;
      rdata <= 24'h000000;
      scl_out <= 1'b1;
      sda_out <= 1'b1;
    end else begin
      state <= next_state;
      tmr <= next_tmr;
      ph <= next_ph;
      bitn <= next_bitn;
      bcnt <= next_bcnt;
      sh <= next_sh;
      dat <= next_dat;
      rdm <= next_rdm;
      mb <= next_mb;
      hsm <= next_hsm;
      hsa <= next_hsa;
      addr_ph <= next_addr_ph;
      cmd_sent <= next_cmd_sent;
      rsh <= next_rsh;
      busy <= next_busy;
      want_data <= next_want;
      done <= next_done;
      nack <= next_nack;
      rdata <= next_rdata;
      scl_out <= next_scl;
      sda_out <= next_sda;
    end
  end

  // Open drain: enable only while pulling low
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_oe <= !next_scl;
      sda_oe <= !next_sda;
    end
  end
endmodule

// File: ddi_slave_mdl.sv
/*
  Behavioural model of the dual DAC slave port on the two-wire bus.
  Assumes open-drain wires with pull-ups resolved by the bench.
*/
`timescale 1ns/1ns
`include "ddi_regs.svh"
module ddi_slave_mdl #(
  parameter logic [1:0] SEL = `DDI_SEL_OPEN,
  parameter logic [23:0] RDATA = 24'h5AC3E1
) (
  // Bus wires
  input wire logic scl,
  input wire logic sda,
  output logic sda_oe,
  // Capture view
  output logic [23:0] word,
  output logic [7:0] nwords,
  output logic hsm
);
  // ----
  // Bit engine
  // ----
  logic [7:0] sh;
  logic [23:0] w;
  logic act = 1'b0, hit = 1'b0, rd = 1'b0;
  int bitn, byten, bi;
  initial begin
    sda_oe = 1'b0;
    nwords = 8'h00;
    hsm = 1'b0;
    word = 24'h000000;
  end
  // Start or repeated start drops a partial block
  always @(negedge sda) if (scl) begin
    act = 1'b1;
    hit = 1'b0;
    bitn = 0;
    byten = 0;
    bi = 0;
  end
  // Stop ends the frame and leaves high speed
  always @(posedge sda) if (scl) begin
    act = 1'b0;
    hsm = 1'b0;
  end
  // Sampled while the clock is high, MSB first
  always @(posedge scl) if (act) begin
    if (bitn < 8) sh = {sh[6:0], sda};
    bitn++;
  end
  // Drive only on the low phase, so SDA never moves under a high clock
  always @(negedge scl) if (act) begin
    sda_oe = 1'b0;
    if (bitn == 9) begin
      bitn = 0;
      byten++;
    end
    if (bitn == 8) begin
      if (byten == 0) begin
        rd = sh[0];
        hit = sh[7:1] == {`DDI_ADDR_FIXED, SEL};
        if (sh[7:3] == 5'h01) hsm = 1'b1;
      end else if (hit && !rd) begin
        if (bi == 0) w[23:16] = sh;
        else if (bi == 1) w[15:8] = sh;
        else w[7:0] = sh;
        if (bi == 2) begin
          word = w;
          nwords++;
        end
        bi = (bi == 2) ? (w[22] ? 1 : 0) : bi + 1;
      end
      sda_oe = hit && !(rd && byten > 0);
    end else if (hit && rd && byten > 0 && byten < 4) begin
      sda_oe = ~RDATA[8 * (3 - byten) + 7 - bitn];
    end
  end
endmodule

// File: ddi_master_chk.sv
/*
  Protocol checker for the bus master, bound to its ports.
  Assumes one clock domain with an active-low async reset.
*/
`timescale 1ns/1ns
module ddi_master_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Handshake
  input wire logic req,
  input wire logic busy,
  input wire logic want_data,
  input wire logic done,
  input wire logic nack,
  // Pins
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_out,
  input wire logic sda_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Open drain: an enabled pin only pulls low
  property p_sda_od; sda_oe |-> !sda_out; endproperty
  a_sda_od: assert property (p_sda_od) else $error("sda driven high");
  property p_scl_od; scl_oe |-> !scl_out; endproperty
  a_scl_od: assert property (p_scl_od) else $error("scl driven high");
  property p_scl_busy; scl_oe |-> busy; endproperty
  a_scl_busy: assert property (p_scl_busy) else $error("scl driven while idle");
  // Stop leaves both lines released
  property p_done_rel; done |-> !sda_oe && !scl_oe; endproperty
  a_done_rel: assert property (p_done_rel) else $error("lines held at stop end");
  property p_done_end; done |-> $past(busy) ##1 !busy; endproperty
  a_done_end: assert property (p_done_end) else $error("done without transfer");
  property p_take; !busy && req && !done |=> busy; endproperty
  a_take: assert property (p_take) else $error("request not taken");
  property p_want_one; want_data |=> !want_data; endproperty
  a_want_one: assert property (p_want_one) else $error("want_data too long");
  property p_nack_hold; nack && !req |=> nack; endproperty
  a_nack_hold: assert property (p_nack_hold) else $error("nack lost");
endmodule

// File: tb_top.sv
/*
  Bench for the bus master against one slave model on a shared bus.
  Assumes header, package, design, model and checker compile first.
*/
`timescale 1ns/1ns
`include "ddi_regs.svh"
module tb_top;
  // ----
  // Signals
  // ----
  localparam logic [23:0] RD_PAT = 24'h5AC3E1;
  logic clk_sys = 1'b0, nrst = 1'b0, req = 1'b0, rd = 1'b0, more = 1'b0, hs = 1'b0, clear_input = 1'b1;
  logic [1:0] speed = ddi_pkg::DDI_SPD_FAST, sel = `DDI_SEL_OPEN;
  logic [2:0] cmd = 3'h0, chan = 3'h0;
  logic [2:0] chs [3] = '{`DDI_CH_A, `DDI_CH_B, `DDI_CH_ALL};
  logic [15:0] code = 16'h0000;
  logic busy, want_data, done, nack, scl_out, scl_oe, sda_out, sda_oe, mdl_oe, hsm;
  logic [23:0] rdata, word;
  logic [7:0] nwords, base;
  int n_errors = 0, num_checks = 0;
  int gap = 0;
  wire scl = ~scl_oe;
  wire sda = ~(sda_oe | mdl_oe);
  always #25 clk_sys = ~clk_sys;
  // Cycles since the last want_data pulse, to judge the bit rate
  always @(posedge clk_sys) gap <= want_data ? 0 : gap + 1;
  ddi_master uut (.clk_sys(clk_sys), .nrst(nrst), .req(req), .rd(rd), .more(more), .hs(hs), .speed(speed),
    .sel(sel), .cmd(cmd), .chan(chan), .code(code), .clear_input(clear_input), .busy(busy),
    .want_data(want_data), .done(done), .nack(nack), .rdata(rdata), .scl_in(scl), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
  ddi_slave_mdl #(.SEL(`DDI_SEL_OPEN), .RDATA(RD_PAT)) mdl (.scl(scl), .sda(sda), .sda_oe(mdl_oe),
    .word(word), .nwords(nwords), .hsm(hsm));
  // ----
  // Tasks
  // ----
  task automatic chk_v(input logic [23:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_f(input logic got, exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One transfer of n blocks; reads and refusals drop req early
  task automatic xfer(input logic r, m, h, input logic [2:0] c, ch, input logic [15:0] d0, d1, input int n);
    int k;
    int t;
    k = 0;
    t = 0;
    {rd, more, hs, cmd, chan, code} = {r, m, h, c, ch, d0};
    req = 1'b1;
    @(negedge clk_sys);
    while (done !== 1'b1 && t < 20000) begin
      if (busy === 1'b1 && (r || nack === 1'b1)) req = 1'b0;
      if (want_data === 1'b1) begin
        k++;
        if (h) chk_f(hsm, 1'b1);
        if (k < n) code = d1;
        else req = 1'b0;
      end
      @(negedge clk_sys);
      t++;
    end
    chk_f(done, 1'b1);
    req = 1'b0;
    // Let one edge pass so a following call never raises req in this step
    @(negedge clk_sys);
  endtask
  task final_report;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ----
  // Sequence
  // ----
  initial begin
    repeat (8) @(negedge clk_sys);
    nrst = 1'b1;
    @(negedge clk_sys);
    chk_f(sda_oe | scl_oe, 1'b0);
    // Every command code, multi-byte bit alternating
    for (int i = 0; i < 8; i++) begin
      base = nwords;
      xfer(1'b0, i[0], 1'b0, 3'(i), chs[i % 3], 16'hFFFF, 16'(i), 2);
      chk_v(word, {1'b0, i[0], 3'(i), chs[i % 3], 16'(i)});
      chk_v(24'(nwords - base), 24'h000002);
    end
    $display("test commands done");
    speed = ddi_pkg::DDI_SPD_STD;
    xfer(1'b1, 1'b0, 1'b0, 3'h0, 3'h0, 16'h0000, 16'h0000, 0);
    chk_v(rdata, RD_PAT);
    chk_f(nack, 1'b0);
    $display("test read done");
    speed = ddi_pkg::DDI_SPD_FAST;
    xfer(1'b0, 1'b0, 1'b1, `DDI_CMD_REF, `DDI_CH_ALL, 16'h0001, 16'h0001, 1);
    chk_v(word, {2'h0, `DDI_CMD_REF, `DDI_CH_ALL, 16'h0001});
    chk_f(hsm, 1'b0);
    $display("test high speed done");
    // Clear during high speed: the second block must go out at the fast rate
    fork
      xfer(1'b0, 1'b1, 1'b1, 3'h0, `DDI_CH_A, 16'h0A0A, 16'h0B0B, 2);
      begin
        do @(negedge clk_sys); while (want_data !== 1'b1);
        clear_input = 1'b0;
        do @(negedge clk_sys); while (want_data !== 1'b1);
        chk_f(gap >= 17 * (`DDI_FAST_NS / `DDI_SYS_NS), 1'b1);
        clear_input = 1'b1;
      end
    join
    chk_v(word, {2'h1, 3'h0, `DDI_CH_A, 16'h0B0B});
    $display("test clear done");
    sel = 2'h1;
    base = nwords;
    xfer(1'b0, 1'b0, 1'b0, 3'h3, 3'h0, 16'h1234, 16'h1234, 1);
    chk_f(nack, 1'b1);
    chk_v(24'(nwords - base), 24'h000000);
    $display("test wrong address done");
    final_report();
  end
  // Watchdog well beyond the expected run of about 40k cycles
  initial begin
    #(80000 * 50);
    n_errors++;
    final_report();
  end
endmodule
bind ddi_master ddi_master_chk chk (.clk_sys(clk_sys), .nrst(nrst), .req(req), .busy(busy),
  .want_data(want_data), .done(done), .nack(nack), .scl_out(scl_out), .scl_oe(scl_oe),
  .sda_out(sda_out), .sda_oe(sda_oe));
